// *** include/dma_page_pkg.sv ***
// Shared constants for the DMA page-address and refresh block and its controller end
`default_nettype none
package dma_page_pkg;
  // Clock and refresh pacing
  localparam int CLK_HZ = 250_000_000;
  localparam int REFRESH_TICK_HZ = 69_799;
  // Longest period rounds down
  localparam int REFRESH_CYCLES = CLK_HZ / REFRESH_TICK_HZ;
  localparam int TICK_W = 12;
  localparam int ROW_W = 9;
  // Channel layout
  localparam int CHAN_COUNT = 8;
  localparam int CHAN_W = 3;
  localparam logic [2:0] CASCADE_CHAN = 3'h4;
  localparam logic [2:0] LAST_BYTE_CHAN = 3'h3;
  // Widths of the address pieces
  localparam int ADDR_W = 24;
  localparam int CTL_ADDR_W = 16;
  localparam int PAGE_W = 8;
  localparam int ENTRY_W = ADDR_W + 1;
  localparam int FIFO_DEPTH = 8;
  // Largest transfer in units (bytes or words)
  localparam logic [16:0] MAX_UNITS = 17'h10000;
  // Page register I/O ports
  localparam logic [7:0] PORT_PAGE_CH0 = 8'h87;
  localparam logic [7:0] PORT_PAGE_CH1 = 8'h83;
  localparam logic [7:0] PORT_PAGE_CH2 = 8'h81;
  localparam logic [7:0] PORT_PAGE_CH3 = 8'h82;
  localparam logic [7:0] PORT_PAGE_CH5 = 8'h8B;
  localparam logic [7:0] PORT_PAGE_CH6 = 8'h89;
  localparam logic [7:0] PORT_PAGE_CH7 = 8'h8A;
  localparam logic [7:0] PORT_PAGE_REFRESH = 8'h8F;
  // Per-channel signalling select, bit set means request/grant pair
  localparam logic [7:0] PORT_CHAN_MODE = 8'h8D;
  // Value of an undriven I/O read
  localparam logic [7:0] IO_FLOAT = 8'hFF;
  // Controller end APB register offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_IOCMD = 12'h004;
  localparam logic [11:0] OFS_IOSTAT = 12'h008;
  localparam logic [11:0] OFS_XFER = 12'h00C;
  localparam logic [11:0] OFS_STAT = 12'h010;
  localparam logic [11:0] OFS_MEMADDR = 12'h014;
  // Field positions in controller end registers
  localparam int CTRL_PCI_LSB = 8;
  localparam int CTRL_STALL_BIT = 16;
  localparam int IOCMD_DATA_LSB = 8;
  localparam int IOCMD_WRITE_BIT = 16;
  localparam int IOSTAT_BUSY_BIT = 8;
  localparam int XFER_COUNT_LSB = 16;
  localparam int STAT_BUSY_BIT = 8;
  localparam int MEM_REFRESH_BIT = 24;

  // Port decode: hit flag and page slot; slot 4 holds the refresh page
  function automatic logic [3:0] pageSlot(input logic [7:0] port);
    unique case (port)
      PORT_PAGE_CH0: pageSlot = 4'h8;
      PORT_PAGE_CH1: pageSlot = 4'h9;
      PORT_PAGE_CH2: pageSlot = 4'hA;
      PORT_PAGE_CH3: pageSlot = 4'hB;
      PORT_PAGE_REFRESH: pageSlot = 4'hC;
      PORT_PAGE_CH5: pageSlot = 4'hD;
      PORT_PAGE_CH6: pageSlot = 4'hE;
      PORT_PAGE_CH7: pageSlot = 4'hF;
      default: pageSlot = 4'h0;
    endcase
  endfunction
endpackage
`default_nettype wire

// *** include/dma_link_if.sv ***
// Link between the page-address block and the controller cores with requesters
`timescale 1ns/1ps
`default_nettype none
interface dma_link_if;
  // I/O port access to page and mode registers
  logic ioValid;
  logic ioWrite;
  logic [7:0] ioPort;
  logic [7:0] ioWdata;
  logic ioAck;
  logic [7:0] ioRdata;
  // Channel requests and grants, two signalling styles
  logic [7:0] lpcReq;
  logic [7:0] pciReqN;
  logic [7:0] lpcAck;
  logic [7:0] pciGntN;
  // Controller low address stream
  logic xferValid;
  logic xferReady;
  logic [15:0] ctlAddr;
  // Full memory address stream
  logic memValid;
  logic memReady;
  logic [23:0] memAddr;
  logic memRefresh;

  modport devEnd (
    input ioValid, ioWrite, ioPort, ioWdata, lpcReq, pciReqN, xferValid, ctlAddr, memReady,
    output ioAck, ioRdata, lpcAck, pciGntN, xferReady, memValid, memAddr, memRefresh
  );
  modport ctlEnd (
    output ioValid, ioWrite, ioPort, ioWdata, lpcReq, pciReqN, xferValid, ctlAddr, memReady,
    input ioAck, ioRdata, lpcAck, pciGntN, xferReady, memValid, memAddr, memRefresh
  );
endinterface
`default_nettype wire

// *** rtl/dma_page_device.sv ***
// Page-address extension, channel arbitration and refresh addressing, with its FIFO
// How it works
// - Channels 0-3 bytes, 4-7 words
// - First controller always beats second controller; here only when no channel holds a grant
// - Channel 4 cascade only, no page
// - Page gives top byte of address
// - Byte channels: page A23-16, controller A15-0
// - Word channels: page A23-17, controller A16-1
// - Word transfers force A00 low
// - Transfer limit 64K units per grant
// - Word channels only for 16-bit parties
// - Page registers at fixed I/O ports
// - Software loads refresh page with zero
// - Refresh reads all 512 rows in turn
// - Refresh row on address bits 8-0
// - Refresh drives A23-17, A19-18 low
// - Refresh paced by 69.799 kHz tick
// - Each channel selects its signalling style
// - Request/grant pair in PC/PCI mode
// - LPC request/ack lines in LPC mode
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Plain FIFO with registered pointers; full and empty from pointer compare
module stream_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  // Pointer arithmetic needs a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_badDepth
    $error("stream_fifo depth must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage words
    logic [PW:0] wrPtr; // Extra bit tells full from empty
    logic [PW:0] rdPtr;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic full;
  logic empty;

  // Status from pointers
  assign empty = (s.wrPtr == s.rdPtr);
  assign full = (s.wrPtr[PW-1:0] == s.rdPtr[PW-1:0]) && (s.wrPtr[PW] != s.rdPtr[PW]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = s.mem[s.rdPtr[PW-1:0]];

  // Push and pop
  always_comb
  begin
    next_s = s;
    if (inValid && !full)
    begin
      next_s.mem[s.wrPtr[PW-1:0]] = inData;
      next_s.wrPtr = s.wrPtr + 1'b1;
    end
    if (outReady && !empty)
    begin
      next_s.rdPtr = s.rdPtr + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end
endmodule

// Device end: page registers, arbitration, address composition, refresh
module dma_page_device
  import dma_page_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Link to controller cores and requesters
  dma_link_if.devEnd link,
  // Toggles on every refresh cycle
  output logic refreshToggle
);
  typedef struct packed {
    logic [CHAN_COUNT-1:0][PAGE_W-1:0] page; // Slot 4 holds refresh page
    logic [7:0] chanMode; // Set: request/grant pair
    logic [7:0] grant; // One-hot granted channel
    logic [16:0] unitCount; // Units moved under this grant
    logic ioAck;
    logic [7:0] ioRdata;
    logic [7:0] lpcAck;
    logic [7:0] pciGntN;
    logic [TICK_W-1:0] tickCnt;
    logic [ROW_W-1:0] row;
    logic refreshPending;
    logic refreshToggle;
  } dev_state_t;

  dev_state_t s;
  dev_state_t next_s;
  logic [7:0] chanReq; // Effective request per channel
  logic fifoInReady;
  logic pushValid;
  logic [ENTRY_W-1:0] pushData;
  logic [CHAN_W-1:0] grantChan;
  logic [ENTRY_W-1:0] popData;

  // Refresh counter must fit its width
  if (REFRESH_CYCLES >= (1 << TICK_W))
  begin : g_badTick
    $error("refresh tick count exceeds counter width");
  end

  // Merge the two signalling styles into one request vector
  always_comb
  begin
    for (int i = 0; i < CHAN_COUNT; i++)
    begin
      chanReq[i] = s.chanMode[i] ? !link.pciReqN[i] : link.lpcReq[i];
    end
    chanReq[CASCADE_CHAN] = 1'b0;
  end

  // Encode the held grant
  always_comb
  begin
    grantChan = '0;
    for (int i = 0; i < CHAN_COUNT; i++)
    begin
      if (s.grant[i])
        grantChan = CHAN_W'(i);
    end
  end

  // Refresh takes the FIFO first; transfers wait behind it
  assign link.xferReady = fifoInReady && !s.refreshPending && (s.grant != '0);

  // Build the entry pushed into the FIFO
  always_comb
  begin
    pushValid = 1'b0;
    pushData = '0;
    if (s.refreshPending)
    begin
      pushValid = 1'b1;
      // Row on low bits; all upper lines forced low
      pushData = {1'b1, {(ADDR_W-ROW_W){1'b0}}, s.row};
    end
    else if (link.xferValid && link.xferReady)
    begin
      pushValid = 1'b1;
      if (grantChan <= LAST_BYTE_CHAN)
        pushData = {1'b0, s.page[grantChan], link.ctlAddr};
      else
        pushData = {1'b0, s.page[grantChan][PAGE_W-1:1], link.ctlAddr, 1'b0};
    end
  end

  // Next state: I/O ports, arbitration, refresh pacing
  always_comb
  begin
    logic [3:0] slot;
    slot = pageSlot(link.ioPort);
    next_s = s;
    next_s.ioAck = 1'b0;
    // One access per held request; ack drops it next cycle
    if (link.ioValid && !s.ioAck)
    begin
      next_s.ioAck = 1'b1;
      next_s.ioRdata = IO_FLOAT;
      if (slot[3])
      begin
        if (link.ioWrite)
          next_s.page[slot[2:0]] = link.ioWdata;
        next_s.ioRdata = s.page[slot[2:0]];
      end
      else if (link.ioPort == PORT_CHAN_MODE)
      begin
        if (link.ioWrite)
          next_s.chanMode = link.ioWdata;
        next_s.ioRdata = s.chanMode;
      end
    end
    // Grant bookkeeping
    if (s.grant != '0)
    begin
      if (link.xferValid && link.xferReady && !s.refreshPending)
      begin
        next_s.unitCount = s.unitCount + 1'b1;
        if (s.unitCount == MAX_UNITS - 1'b1)
          next_s.grant = '0;
      end
      if (!chanReq[grantChan])
        next_s.grant = '0;
    end
    else
    begin
      next_s.unitCount = '0;
      // Lowest number wins, so channels 0-3 beat 5-7
      for (int i = CHAN_COUNT - 1; i >= 0; i--)
      begin
        if (chanReq[i])
          next_s.grant = 8'h01 << i;
      end
    end
    // Style taken from the new mode so a mode write never splits a grant
    next_s.lpcAck = next_s.grant & ~next_s.chanMode;
    next_s.pciGntN = ~(next_s.grant & next_s.chanMode);
    // Refresh leaves once it is in the FIFO
    if (s.refreshPending && fifoInReady)
    begin
      next_s.refreshPending = 1'b0;
      next_s.row = s.row + 1'b1;
      next_s.refreshToggle = !s.refreshToggle;
    end
    // Refresh tick from the divider; comes last so a new tick beats the clear
    if (s.tickCnt == TICK_W'(REFRESH_CYCLES - 1))
    begin
      next_s.tickCnt = '0;
      next_s.refreshPending = 1'b1;
    end
    else
    begin
      next_s.tickCnt = s.tickCnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s <= '0;
      s.pciGntN <= 8'hFF;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Addresses queue here so the memory side may stall
  stream_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .inValid(pushValid),
    .inReady(fifoInReady),
    .inData(pushData),
    .outValid(link.memValid),
    .outReady(link.memReady),
    .outData(popData)
  );

  // Link outputs
  assign link.memAddr = popData[ADDR_W-1:0];
  assign link.memRefresh = popData[ADDR_W];
  assign link.ioAck = s.ioAck;
  assign link.ioRdata = s.ioRdata;
  assign link.lpcAck = s.lpcAck;
  assign link.pciGntN = s.pciGntN;
  assign refreshToggle = s.refreshToggle;
endmodule
`default_nettype wire

// *** rtl/dma_page_ctl.sv ***
// Controller end: APB registers drive port accesses, requests and address streams
`timescale 1ns/1ps
`default_nettype none
module dma_page_ctl
  import dma_page_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to the page-address block
  dma_link_if.ctlEnd link
);
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [7:0] lpcReq;
    logic [7:0] pciReqN;
    logic memReady;
    logic ioValid;
    logic ioWrite;
    logic [7:0] ioPort;
    logic [7:0] ioWdata;
    logic [7:0] ioRdata; // Last read result
    logic xferValid;
    logic [CTL_ADDR_W-1:0] ctlAddr;
    logic [15:0] beatsLeft;
    logic [ADDR_W:0] lastMem; // Refresh flag and address
  } ctl_state_t;

  ctl_state_t s;
  ctl_state_t next_s;
  logic [7:0] granted;

  // Either style of grant counts
  assign granted = link.lpcAck | ~link.pciGntN;

  // Next state: bus, port command, stream
  always_comb
  begin
    logic [15:0] beats;
    logic doWrite;
    beats = s.beatsLeft;
    doWrite = psel && penable && s.pready && pwrite;
    next_s = s;
    // Answer in the first access cycle
    next_s.pready = psel && !penable;
    if (psel && !penable)
    begin
      next_s.pslverr = 1'b0;
      next_s.prdata = '0;
      unique case (paddr)
        OFS_CTRL: next_s.prdata = {15'h0000, !s.memReady, ~s.pciReqN, s.lpcReq};
        OFS_IOCMD: next_s.prdata = {15'h0000, s.ioWrite, s.ioWdata, s.ioPort};
        OFS_IOSTAT: next_s.prdata = {23'h000000, s.ioValid, s.ioRdata};
        OFS_XFER: next_s.prdata = {s.beatsLeft, s.ctlAddr};
        OFS_STAT: next_s.prdata = {23'h000000, s.xferValid, granted};
        OFS_MEMADDR: next_s.prdata = {7'h00, s.lastMem};
        default: next_s.pslverr = 1'b1; // Unmapped offset
      endcase
    end
    // Port access completes on the acknowledge
    if (s.ioValid && link.ioAck)
    begin
      next_s.ioValid = 1'b0;
      next_s.ioRdata = link.ioRdata;
    end
    // Stream the controller address while granted
    if (s.xferValid && link.xferReady)
    begin
      beats = s.beatsLeft - 1'b1;
      next_s.ctlAddr = s.ctlAddr + 1'b1;
    end
    next_s.beatsLeft = beats;
    // Offer a beat while beats remain and some channel is granted
    next_s.xferValid = (beats != '0) && (granted != '0);
    // Drain memory addresses unless software stalls
    if (link.memValid && s.memReady)
      next_s.lastMem = {link.memRefresh, link.memAddr};
    // Register writes take effect at the completing edge
    if (doWrite)
    begin
      unique case (paddr)
        OFS_CTRL:
        begin
          next_s.lpcReq = pwdata[7:0];
          next_s.pciReqN = ~pwdata[CTRL_PCI_LSB +: 8];
          next_s.memReady = !pwdata[CTRL_STALL_BIT];
        end
        OFS_IOCMD:
        begin
          // Ignored while a port access is still open
          if (!s.ioValid)
          begin
            next_s.ioValid = 1'b1;
            next_s.ioPort = pwdata[7:0];
            next_s.ioWdata = pwdata[IOCMD_DATA_LSB +: 8];
            next_s.ioWrite = pwdata[IOCMD_WRITE_BIT];
          end
        end
        OFS_XFER:
        begin
          // Ignored while a stream is running
          if (s.beatsLeft == '0)
          begin
            next_s.ctlAddr = pwdata[CTL_ADDR_W-1:0];
            next_s.beatsLeft = pwdata[XFER_COUNT_LSB +: 16];
            next_s.xferValid = 1'b0;
          end
        end
        default:
        begin
          next_s.pslverr = s.pslverr;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s <= '0;
      s.pciReqN <= 8'hFF;
      s.memReady <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign link.ioValid = s.ioValid;
  assign link.ioWrite = s.ioWrite;
  assign link.ioPort = s.ioPort;
  assign link.ioWdata = s.ioWdata;
  assign link.lpcReq = s.lpcReq;
  assign link.pciReqN = s.pciReqN;
  assign link.xferValid = s.xferValid;
  assign link.ctlAddr = s.ctlAddr;
  assign link.memReady = s.memReady;
endmodule
`default_nettype wire

// *** dv/dma_page_props.sv ***
// Concurrent checks on the link between the page block and its controller end
`timescale 1ns/1ps
`default_nettype none
module dma_page_props
  import dma_page_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Port access
  input wire logic ioValid,
  input wire logic ioWrite,
  input wire logic [7:0] ioPort,
  input wire logic [7:0] ioWdata,
  input wire logic ioAck,
  // Requests and grants
  input wire logic [7:0] lpcReq,
  input wire logic [7:0] pciReqN,
  input wire logic [7:0] lpcAck,
  input wire logic [7:0] pciGntN,
  // Address stream
  input wire logic memValid,
  input wire logic memReady,
  input wire logic [23:0] memAddr,
  input wire logic memRefresh
);
  // Mirror of the style select, taken when the port write is accepted
  logic [7:0] mode;
  // Requests in each channel's own style, cascade channel masked
  logic [7:0] req;
  // Lowest requesting channel
  logic [7:0] win;
  // Grants in either style
  logic [7:0] gnt;
  logic idle;

  // Style mirror follows port writes
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      mode <= 8'h00;
    else if (ioValid && !ioAck && ioWrite && ioPort == PORT_CHAN_MODE)
      mode <= ioWdata;
  end
  assign req = ((lpcReq & ~mode) | (~pciReqN & mode)) & 8'hEF;
  assign win = req & (~req + 8'h01);
  assign gnt = lpcAck | ~pciGntN;
  assign idle = gnt == 8'h00;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Port access: request seen, one-cycle answer
  sequence s_io_req;
    ioValid && !ioAck;
  endsequence
  sequence s_io_ans;
    ioAck ##1 !ioAck;
  endsequence

  a_io_answer: assert property (s_io_req |=> s_io_ans)
    else $error("port access not answered with a single pulse");
  a_no_cascade: assert property (!lpcAck[4] && pciGntN[4])
    else $error("cascade channel was granted");
  // Only after a full idle cycle is a fresh grant owed
  a_lowest_wins: assert property (idle && $past(idle) && req != 8'h00 |=> gnt == $past(win))
    else $error("grant did not go to the lowest requester");
  a_lpc_style: assert property ((lpcAck & mode) == 8'h00)
    else $error("line grant on a pair-style channel");
  a_pci_style: assert property ((~pciGntN & ~mode) == 8'h00)
    else $error("pair grant on a line-style channel");
  a_grant_single: assert property ($onehot0(gnt))
    else $error("more than one grant");
  a_grant_drop: assert property (!idle && (gnt & req) == 8'h00 |=> idle)
    else $error("grant outlived its request");
  a_refresh_high: assert property (memValid && memRefresh |-> memAddr[23:9] == 15'h0000)
    else $error("refresh address upper lines not low");
  a_mem_hold: assert property (memValid && !memReady |=> memValid && $stable(memAddr))
    else $error("stream head changed while stalled");
endmodule
`default_nettype wire

// *** dv/dma_page_address_refresh_tb_top.sv ***
// Bench joining controller end and page block, with a behavioural address model
`timescale 1ns/1ps
`default_nettype none
module dma_page_address_refresh_tb_top
  import dma_page_pkg::*;
();
  // APB side
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, perr, refreshToggle;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  // Counters and model state
  int bad_count, checks, seed, acc, rows, cyc, lastRef, curChan;
  // Page model per channel; slot 4 stands for the refresh page
  logic [7:0] pg [8];
  logic [7:0] portOf [8] = '{PORT_PAGE_CH0, PORT_PAGE_CH1, PORT_PAGE_CH2, PORT_PAGE_CH3,
    PORT_PAGE_REFRESH, PORT_PAGE_CH5, PORT_PAGE_CH6, PORT_PAGE_CH7};
  // Expected full addresses in stream order
  logic [23:0] expq [$];

  dma_link_if link();
  dma_page_device #(.DEPTH(FIFO_DEPTH)) u_dma_page_device (.clk_sys(clk_sys), .rst(rst),
    .link(link), .refreshToggle(refreshToggle));
  dma_page_ctl u_dma_page_ctl (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  dma_page_props u_dma_page_props (.clk_sys(clk_sys), .rst(rst), .ioValid(link.ioValid),
    .ioWrite(link.ioWrite), .ioPort(link.ioPort), .ioWdata(link.ioWdata), .ioAck(link.ioAck),
    .lpcReq(link.lpcReq), .pciReqN(link.pciReqN), .lpcAck(link.lpcAck),
    .pciGntN(link.pciGntN), .memValid(link.memValid), .memReady(link.memReady),
    .memAddr(link.memAddr), .memRefresh(link.memRefresh));

  // Free-running 250 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Compare and count
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", w, e, g);
    end
  endtask

  // A used-up bound ends the run
  task automatic tmo(input int n, input int lim, input string w);
    if (n >= lim)
    begin
      bad_count++;
      $display("BAD wait %s exp done got stuck", w);
      test_done();
    end
  endtask

  // One APB transfer; extra edge after release keeps psel from being set twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
    tmo(n, 64, "apb");
  endtask

  // Port access through the command register, polled until idle
  task automatic io(input logic w, input logic [7:0] p, input logic [7:0] d,
    output logic [7:0] r);
    logic [31:0] v;
    int n;
    apb(1'b1, OFS_IOCMD, {15'h0000, w, d, p}, v);
    n = 0;
    do
    begin
      apb(1'b0, OFS_IOSTAT, 32'h0, v);
      n++;
    end
    while (v[IOSTAT_BUSY_BIT] !== 1'b0 && n < 64);
    tmo(n, 64, "io");
    r = v[7:0];
  endtask

  // Wait for a grant pattern, then compare it
  task automatic grant(input logic [7:0] lpc, input logic [7:0] gn);
    int n;
    n = 0;
    while ({link.lpcAck, link.pciGntN} !== {lpc, gn} && n < 64)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk("grant", {lpc, gn}, {link.lpcAck, link.pciGntN});
  endtask

  // Wait until all beats are out of the FIFO
  task automatic drain(input int total);
    int n;
    n = 0;
    while ((acc != total || expq.size() != 0) && n < 256)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk("beats", total, acc);
  endtask

  // Stream monitor: model composes the address, design result is compared
  always @(posedge clk_sys)
  begin
    cyc++;
    if (rst === 1'b0 && link.xferValid === 1'b1 && link.xferReady === 1'b1)
    begin
      acc++;
      // Byte channels keep the whole page, word channels shift and force bit 0 low
      expq.push_back(curChan < 4 ? {pg[curChan], link.ctlAddr} :
        {pg[curChan][7:1], link.ctlAddr, 1'b0});
    end
    if (rst === 1'b0 && link.memValid === 1'b1 && link.memReady === 1'b1)
    begin
      if (link.memRefresh === 1'b1)
      begin
        chk("refresh row", {15'h0000, rows[8:0]}, link.memAddr);
        rows++;
        chk("toggle", rows[0], refreshToggle);
        if (rows > 1 && expq.size() == 0)
          chk("refresh gap", REFRESH_CYCLES, cyc - lastRef);
        lastRef = cyc;
      end
      else if (expq.size() == 0)
        chk("stray beat", 0, 1);
      else
        chk("mem addr", expq.pop_front(), link.memAddr);
    end
  end

  // Main sequence
  initial
  begin
    logic [31:0] v;
    logic [7:0] r;
    int n;
    seed = 32'hAF0D8C33;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {bad_count, checks, acc, rows, cyc, lastRef, curChan} = '0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    // Random pages everywhere, refresh page kept zero
    for (int c = 0; c < 8; c++)
    begin
      pg[c] = (c == 4) ? 8'h00 : 8'($random(seed));
      io(1'b1, portOf[c], pg[c], r);
    end
    for (int c = 0; c < 8; c++)
    begin
      io(1'b0, portOf[c], 8'h00, r);
      chk("page", pg[c], r);
    end
    io(1'b1, 8'h80, 8'h5A, r);
    io(1'b0, 8'h80, 8'h00, r);
    chk("unmapped port", IO_FLOAT, r);
    apb(1'b0, 12'h0FC, 32'h0, v);
    chk("apb error", 1, perr);
    $display("test registers done");
    // Stalled far side: FIFO fills, then drains
    curChan = 2;
    apb(1'b1, OFS_CTRL, 32'h0001_0004, v);
    grant(8'h04, 8'hFF);
    apb(1'b1, OFS_XFER, 32'h000C_1230, v);
    repeat (40) @(posedge clk_sys);
    chk("fifo fill", FIFO_DEPTH, acc);
    apb(1'b1, OFS_CTRL, 32'h0000_0004, v);
    drain(12);
    $display("test fifo done");
    // Word channel with a random start address
    apb(1'b1, OFS_CTRL, 32'h0, v);
    grant(8'h00, 8'hFF);
    curChan = 5;
    apb(1'b1, OFS_CTRL, 32'h0000_0020, v);
    grant(8'h20, 8'hFF);
    apb(1'b1, OFS_XFER, {16'h0004, 16'($random(seed))}, v);
    drain(16);
    $display("test word done");
    // First controller beats second, cascade never granted
    apb(1'b1, OFS_CTRL, 32'h0, v);
    grant(8'h00, 8'hFF);
    apb(1'b1, OFS_CTRL, 32'h0000_0032, v);
    grant(8'h02, 8'hFF);
    apb(1'b0, OFS_STAT, 32'h0, v);
    chk("stat grant", 32'h0000_0002, v);
    apb(1'b1, OFS_CTRL, 32'h0000_0010, v);
    grant(8'h00, 8'hFF);
    repeat (8) @(posedge clk_sys);
    chk("cascade idle", 8'h00, link.lpcAck);
    $display("test priority done");
    // Pair style on channel 6: line request ignored, pair request granted
    io(1'b1, PORT_CHAN_MODE, 8'h40, r);
    apb(1'b1, OFS_CTRL, 32'h0000_0040, v);
    repeat (8) @(posedge clk_sys);
    chk("style ignore", 8'h00, link.lpcAck);
    curChan = 6;
    apb(1'b1, OFS_CTRL, 32'h0000_4000, v);
    grant(8'h00, 8'hBF);
    apb(1'b1, OFS_XFER, {16'h0003, 16'($random(seed))}, v);
    drain(19);
    apb(1'b1, OFS_CTRL, 32'h0, v);
    $display("test style done");
    // Two refresh entries, spacing and rows checked by the monitor
    n = 0;
    while (rows < 2 && n < 9000)
    begin
      @(posedge clk_sys);
      n++;
    end
    tmo(n, 9000, "refresh");
    // Last popped entry is refresh row 1 with its flag
    apb(1'b0, OFS_MEMADDR, 32'h0, v);
    chk("last mem", 32'h0100_0001, v);
    $display("test refresh done");
    test_done();
  end
endmodule
`default_nettype wire
